// *** inc/acs_pkg.sv ***
// Purpose: constants for the acquisition control and status register
// Assumes: 125 MHz logic clock, 16-bit register port with word addresses
// Notes: sync times are in milliseconds, cycle counts derive from them
package acs_pkg;

  localparam int CLK_KHZ = 125000;

  // register map, word address on the card's register port
  localparam logic [7:0] ADDR_CARD_CONTROL_STATUS = 8'h02;
  localparam logic [15:0] CARD_CONTROL_STATUS_RESET = 16'h0000;

  // field positions
  localparam int BIT_MASTER = 15;
  localparam int BIT_CABLE = 14;
  localparam int BIT_ENDED = 13;
  localparam int BIT_STATE_HI = 12;
  localparam int BIT_STATE_LO = 10;
  localparam int BIT_FIFO_AF = 9;
  localparam int BIT_ERROR = 8;
  localparam int BIT_MODE_HI = 7;
  localparam int BIT_MODE_LO = 6;
  localparam int BIT_SKIP = 5;
  localparam int BIT_SYNC_SEL = 4;
  localparam int BIT_SYNC_NEED = 3;
  localparam int BIT_LONG_SYNC = 2;
  localparam int BIT_ARM = 1;
  localparam int BIT_SOFT_RESET = 0;

  // synchronisation lengths as printed, then in clock cycles
  localparam int SYNC_SHORT_MS = 950;
  localparam int SYNC_LONG_MS = 8200;
  localparam int SYNC_SHORT_CYCLES = SYNC_SHORT_MS * CLK_KHZ;
  localparam int SYNC_LONG_CYCLES = SYNC_LONG_MS * CLK_KHZ;
  localparam int SYNC_CNT_W = 30;

  // converter alignment and soft reset lengths
  localparam int CONV_SYNC_CYCLES = 16;
  localparam int SOFT_RESET_CYCLES = 8;
  localparam int SOFT_RESET_CNT_W = 4;

  typedef enum logic [2:0] {
    state_idle = 3'b000,
    state_freq_sync = 3'b001,
    state_converter_sync = 3'b010,
    state_armed = 3'b011,
    state_await_trigger = 3'b100,
    state_acquiring = 3'b101
  } acs_state_t;

endpackage

// *** hdl/acs_soft_reset.sv ***
// Purpose: stretches a soft reset request into a fixed busy window
// Assumes: start is a one-cycle pulse from a register write
// Notes: a start while busy restarts nothing; the window simply runs out
`timescale 1ns/100ps
module acs_soft_reset
  import acs_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic start,
  output logic busy
);

  logic [SOFT_RESET_CNT_W-1:0] count;
  wire last = (count == SOFT_RESET_CNT_W'(SOFT_RESET_CYCLES - 1));

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      count <= '0;
    end else if (!busy) begin
      busy <= start;
      count <= '0;
    end else begin
      busy <= !last;
      count <= count + SOFT_RESET_CNT_W'(1);
    end
  end

endmodule

// *** hdl/acs_control_status.sv ***
// Purpose: card control and status register with the main sequencer
// Assumes: register port and pins are synchronous to clock
// Notes: long sync counts are parameters so simulation can shorten them
`timescale 1ns/100ps
// Operation
// - master role makes the sync on this card itself; trigger and done still come in as inputs
// - bit 14 shows cable detection and holds steady in normal operation
// - bit 13 sets on normal end or skip, never on error end
// - the arming command clears the acquisition-ended bit
// - bits 12:10 show the main sequencer state code
// - bit 9 mirrors the sample FIFO almost-full flag
// - bit 8 shows the common error flag from the error register
// - bits 7:6 return the present levels of the two mode pins
// - writing 1 to bit 5 ends acquisition as a non-error end
// - master makes sync itself; slave takes sync from bit 4's source
// - bit 3 chooses launch with or without a synchronisation phase
// - bit 2 on a master lengthens sync from about 950 to 8200 ms
// - writing 1 to bit 1 arms, leaving idle; writing 0 does nothing
// - writing 1 to bit 0 resets acquisition logic, registers kept
// - bit 0 reads 1 while soft reset runs, 0 when card ready
// - the register sits at word address 2, byte 0x04, read and write
module acs_control_status
  import acs_pkg::*;
#(
  parameter int SYNC_SHORT = SYNC_SHORT_CYCLES,
  parameter int SYNC_LONG = SYNC_LONG_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic serial_cable_detected,
  input wire logic fifo_almost_full,
  input wire logic error_flag,
  input wire logic [1:0] mode_pins,
  input wire logic backplane_trigger_in_b,
  input wire logic front_trigger_in_2,
  input wire logic acquisition_trigger,
  input wire logic acquisition_done,
  input wire logic acquisition_error,
  output logic master_role,
  output logic sync_out,
  output logic converter_sync,
  output logic acquiring,
  output logic acquisition_reset,
  output logic [2:0] main_state_code
);

  logic sync_select;
  logic sync_need;
  logic long_sync;
  logic acquisition_ended;
  logic cable_latched;
  logic cable_taken;
  logic ext_sync_prev;
  logic soft_busy;
  logic [SYNC_CNT_W-1:0] count;
  acs_state_t state;
  acs_state_t next_state;
  acs_state_t launch_state;

  function automatic logic [SYNC_CNT_W-1:0] to_cnt(input int value);
    to_cnt = SYNC_CNT_W'(value - 1);
  endfunction

  wire hit = (reg_addr == ADDR_CARD_CONTROL_STATUS);
  wire wr = reg_write && hit;
  wire arm_cmd = wr && reg_wdata[BIT_ARM];
  wire skip_cmd = wr && reg_wdata[BIT_SKIP];
  wire soft_start = wr && reg_wdata[BIT_SOFT_RESET];

  // a write that arms brings the mode it arms with
  wire need_now = wr ? reg_wdata[BIT_SYNC_NEED] : sync_need;
  wire role_now = wr ? reg_wdata[BIT_MASTER] : master_role;
  assign launch_state = need_now ? state_freq_sync : state_armed;

  // slave sync comes from the chosen external line
  wire ext_sync = sync_select ? front_trigger_in_2
                              : backplane_trigger_in_b;
  wire ext_sync_rise = ext_sync && !ext_sync_prev;

  // master counts its own sync window; longer window when long_sync is asked
  wire [SYNC_CNT_W-1:0] sync_last = long_sync ? to_cnt(SYNC_LONG)
                                              : to_cnt(SYNC_SHORT);
  wire master_sync_done = (count == sync_last);
  wire sync_done = master_role ? master_sync_done : ext_sync_rise;
  wire conv_done = (count == to_cnt(CONV_SYNC_CYCLES));

  // normal end or skip while active; error end does not count
  wire running = (state != state_idle);
  wire normal_end = (state == state_acquiring) && acquisition_done
                    && !acquisition_error;
  wire skip_end = skip_cmd && running;
  wire set_ended = (normal_end || skip_end) && !soft_busy;

  wire [15:0] status_word = {
    master_role,
    cable_latched,
    acquisition_ended,
    state,
    fifo_almost_full,
    error_flag,
    mode_pins,
    1'b0,
    sync_select,
    sync_need,
    long_sync,
    1'b0,
    soft_busy
  };

  always_comb begin
    next_state = state;
    case (state)
      state_idle: begin
        if (arm_cmd) begin
          next_state = launch_state;
        end
      end
      state_freq_sync: begin
        if (sync_done) begin
          next_state = state_converter_sync;
        end
      end
      state_converter_sync: begin
        if (conv_done) begin
          next_state = state_armed;
        end
      end
      state_armed: begin
        next_state = state_await_trigger;
      end
      state_await_trigger: begin
        if (acquisition_trigger) begin
          next_state = state_acquiring;
        end
      end
      state_acquiring: begin
        if (acquisition_done || acquisition_error) begin
          next_state = state_idle;
        end
      end
      default: begin
        next_state = state_idle;
      end
    endcase
    if (skip_cmd || soft_busy) begin
      next_state = state_idle;
    end
  end

  acs_soft_reset u_soft_reset (
    .clock(clock),
    .rst_n(rst_n),
    .start(soft_start),
    .busy(soft_busy)
  );

  // writable control fields; soft reset leaves them alone
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      master_role <= CARD_CONTROL_STATUS_RESET[BIT_MASTER];
    end else if (wr) begin
      master_role <= reg_wdata[BIT_MASTER];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync_select <= CARD_CONTROL_STATUS_RESET[BIT_SYNC_SEL];
    end else if (wr) begin
      sync_select <= reg_wdata[BIT_SYNC_SEL];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync_need <= CARD_CONTROL_STATUS_RESET[BIT_SYNC_NEED];
    end else if (wr) begin
      sync_need <= reg_wdata[BIT_SYNC_NEED];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      long_sync <= CARD_CONTROL_STATUS_RESET[BIT_LONG_SYNC];
    end else if (wr) begin
      long_sync <= reg_wdata[BIT_LONG_SYNC];
    end
  end

  // ended flag: set wins over the arming clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      acquisition_ended <= CARD_CONTROL_STATUS_RESET[BIT_ENDED];
    end else if (set_ended) begin
      acquisition_ended <= 1'b1;
    end else if (arm_cmd) begin
      acquisition_ended <= 1'b0;
    end
  end

  // cable level caught once after reset release, then held
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cable_taken <= 1'b0;
    end else begin
      cable_taken <= 1'b1;
    end
  end

  // a cable plugged later is not seen until the next reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cable_latched <= 1'b0;
    end else if (!cable_taken) begin
      cable_latched <= serial_cable_detected;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= state_idle;
    end else begin
      state <= next_state;
    end
  end

  // one counter serves both sync phases; cleared on every state change
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (next_state != state) begin
      count <= '0;
    end else if (running) begin
      count <= count + SYNC_CNT_W'(1);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ext_sync_prev <= 1'b0;
    end else begin
      ext_sync_prev <= ext_sync;
    end
  end

  // derived outputs, one flop each
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync_out <= 1'b0;
    end else begin
      sync_out <= role_now && (next_state == state_freq_sync);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      converter_sync <= 1'b0;
    end else begin
      converter_sync <= (next_state == state_converter_sync);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      acquiring <= 1'b0;
    end else begin
      acquiring <= (next_state == state_acquiring);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      acquisition_reset <= 1'b0;
    end else begin
      acquisition_reset <= soft_busy;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      main_state_code <= state_idle;
    end else begin
      main_state_code <= next_state;
    end
  end

  // read data: the live status word, zero off the map
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_read) begin
      reg_rdata <= hit ? status_word : 16'h0000;
    end
  end

endmodule

// *** sim/acs_control_status_asserts.sv ***
// Purpose: port checks for the card control and status register
// Assumes: read data lands one cycle after the read edge
// Notes: arm checks skip the soft reset window, where arm is moot
`timescale 1ns/100ps
module acs_control_status_asserts
  import acs_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic fifo_almost_full,
  input wire logic [1:0] mode_pins,
  input wire logic master_role,
  input wire logic acquiring,
  input wire logic acquisition_reset,
  input wire logic [2:0] main_state_code
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire wr2 = reg_write && reg_addr == 8'h02;
  wire rd2 = reg_read && reg_addr == 8'h02;
  wire calm = main_state_code == 3'h0 && !acquisition_reset;
  wire arm_ok = wr2 && reg_wdata[1] && !reg_wdata[5] && !reg_wdata[0] && calm;
  sequence s_armed;
    main_state_code == 3'h3 ##1 main_state_code == 3'h4;
  endsequence
  sequence s_rst_win;
    (acquisition_reset && main_state_code == 3'h0) [*8] ##1 !acquisition_reset;
  endsequence
  property p_arm;
    arm_ok && !reg_wdata[3] |=> s_armed;
  endproperty
  property p_sync;
    arm_ok && reg_wdata[3] |=> main_state_code == 3'h1;
  endproperty
  property p_soft;
    wr2 && reg_wdata[0] && !acquisition_reset |-> ##2 s_rst_win;
  endproperty
  property p_skip;
    wr2 && reg_wdata[5] && !reg_wdata[1] && acquiring |=> main_state_code == 3'h0;
  endproperty
  property p_role;
    wr2 |=> master_role == $past(reg_wdata[15]);
  endproperty
  property p_acq;
    acquiring == (main_state_code == 3'h5);
  endproperty
  property p_code;
    main_state_code <= 3'h5;
  endproperty
  property p_live;
    rd2 |=> reg_rdata[9] == $past(fifo_almost_full)
      && reg_rdata[7:6] == $past(mode_pins);
  endproperty
  property p_stat;
    rd2 |=> reg_rdata[12:10] == $past(main_state_code);
  endproperty
  property p_unmap;
    reg_read && reg_addr != 8'h02 |=> reg_rdata == 16'h0000;
  endproperty
  a_arm: assert property (p_arm)
    else $error("arm did not reach armed then await");
  a_sync: assert property (p_sync)
    else $error("sync arm did not enter freq sync");
  a_soft: assert property (p_soft)
    else $error("soft reset window wrong");
  a_skip: assert property (p_skip)
    else $error("skip did not end acquisition");
  a_role: assert property (p_role)
    else $error("role output not from bit 15");
  a_acq: assert property (p_acq)
    else $error("acquiring and state code disagree");
  a_code: assert property (p_code)
    else $error("reserved state code");
  a_live: assert property (p_live)
    else $error("live status bits wrong");
  a_stat: assert property (p_stat)
    else $error("state bits differ from state code");
  a_unmap: assert property (p_unmap)
    else $error("unmapped read not zero");
endmodule
bind acs_control_status acs_control_status_asserts u_chk (.clock(clock),
  .rst_n(rst_n), .reg_addr(reg_addr), .reg_write(reg_write),
  .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .fifo_almost_full(fifo_almost_full), .mode_pins(mode_pins),
  .master_role(master_role), .acquiring(acquiring),
  .acquisition_reset(acquisition_reset), .main_state_code(main_state_code));

// *** sim/tb.sv ***
// Purpose: directed checks of the card control and status register
// Assumes: sync lengths shortened to 20 and 40 cycles
// Notes: cable input flips only around a mid-run reset
`timescale 1ns/100ps
module tb;
  import acs_pkg::*;
  logic clock, rst_n, we, re, faf, err, bpb, fp2, trg, done, aerr;
  logic master, sync_o, conv, acq, arst, cable;
  logic [7:0] addr;
  logic [15:0] wd, rd_v;
  logic [1:0] mode;
  logic [2:0] code;
  int error_cnt, samples_checked, cyc, n, s, t;
  acs_control_status #(.SYNC_SHORT(20), .SYNC_LONG(40)) dut (.clock(clock),
    .rst_n(rst_n), .reg_addr(addr), .reg_write(we), .reg_read(re),
    .reg_wdata(wd), .reg_rdata(rd_v), .serial_cable_detected(cable),
    .fifo_almost_full(faf), .error_flag(err), .mode_pins(mode),
    .backplane_trigger_in_b(bpb), .front_trigger_in_2(fp2),
    .acquisition_trigger(trg), .acquisition_done(done),
    .acquisition_error(aerr), .master_role(master), .sync_out(sync_o),
    .converter_sync(conv), .acquiring(acq), .acquisition_reset(arst),
    .main_state_code(code));
  task automatic chk(input logic [15:0] v, input logic [15:0] e);
    samples_checked++;
    if (v !== e) begin
      error_cnt++;
      $display("ERROR %0t got %h want %h", $time, v, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wd <= d;
    we <= 1'b1;
    @(posedge clock);
    we <= 1'b0;
  endtask
  // read data is sampled once it has settled after the answer edge
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    addr <= a;
    re <= 1'b1;
    @(posedge clock);
    re <= 1'b0;
    @(posedge clock);
    #1;
  endtask
  task automatic wst(input logic [2:0] st);
    n = 0;
    while (code !== st && n < 300) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk(16'(code), 16'(st));
  endtask
  task automatic t_regs();
    rd(8'h02);
    chk(rd_v, 16'h4280);
    @(posedge clock);
    faf <= 1'b0;
    err <= 1'b1;
    mode <= 2'b01;
    rd(8'h02);
    chk(rd_v, 16'h4140);
    err <= 1'b0;
    rd(8'h03);
    chk(rd_v, 16'h0000);
    wr(8'h03, 16'h8000);
    rd(8'h02);
    chk(16'(rd_v[15]), 16'h0000);
  endtask
  task automatic t_run();
    wr(8'h02, 16'h0002);
    wst(3'h4);
    @(posedge clock);
    trg <= 1'b1;
    done <= 1'b1;
    wst(3'h5);
    wst(3'h0);
    done <= 1'b0;
    rd(8'h02);
    chk(16'(rd_v[13]), 16'h0001);
    wr(8'h02, 16'h0002);
    rd(8'h02);
    chk(16'(rd_v[13]), 16'h0000);
    wst(3'h5);
    @(posedge clock);
    aerr <= 1'b1;
    wst(3'h0);
    aerr <= 1'b0;
    trg <= 1'b0;
    rd(8'h02);
    chk(16'(rd_v[13]), 16'h0000);
    wr(8'h02, 16'h0002);
    wst(3'h4);
    wr(8'h02, 16'h0020);
    wst(3'h0);
    rd(8'h02);
    chk(rd_v & 16'h2022, 16'h2000);
  endtask
  task automatic t_sync(input logic [15:0] d, output int len);
    wr(8'h02, d);
    wst(3'h1);
    chk(16'(sync_o), 16'h0001);
    wst(3'h2);
    len = n;
    chk(16'(conv), 16'h0001);
    wst(3'h4);
    wr(8'h02, 16'h8020);
    wst(3'h0);
  endtask
  task automatic t_slave();
    wr(8'h02, 16'h001A);
    @(posedge clock);
    bpb <= 1'b1;
    repeat (30) @(posedge clock);
    #1;
    chk({15'h0, sync_o}, 16'h0000);
    chk(16'(code), 16'h0001);
    fp2 <= 1'b1;
    wst(3'h2);
    bpb <= 1'b0;
    fp2 <= 1'b0;
    @(posedge clock);
    trg <= 1'b1;
    wst(3'h5);
    wr(8'h02, 16'h0019);
    rd(8'h02);
    chk(16'(rd_v[0]), 16'h0001);
    for (int i = 0; i < 20 && rd_v[0] !== 1'b0; i++) rd(8'h02);
    chk(rd_v & 16'h1C19, 16'h0018);
    wr(8'h02, 16'h000A);
    repeat (10) @(posedge clock);
    #1;
    chk(16'(code), 16'h0001);
    bpb <= 1'b1;
    wst(3'h2);
    bpb <= 1'b0;
    wst(3'h5);
    wr(8'h02, 16'h0020);
    wst(3'h0);
    trg <= 1'b0;
  endtask
  task automatic t_cable();
    @(posedge clock);
    cable <= 1'b0;
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    rd(8'h02);
    chk(rd_v, 16'h0040);
    cable <= 1'b1;
    rd(8'h02);
    chk(16'(rd_v[14]), 16'h0000);
  endtask
  task automatic summarize();
    if (error_cnt == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // ceiling well above the few hundred cycles the scenarios use
  always @(posedge clock) begin
    cyc++;
    if (cyc > 20000) begin
      error_cnt++;
      $display("ERROR %0t timeout", $time);
      summarize();
    end
  end
  initial begin
    {rst_n, we, re, err, bpb, fp2, trg, done, aerr} = 9'h000;
    faf = 1'b1;
    cable = 1'b1;
    mode = 2'b10;
    addr = 8'h00;
    wd = 16'h0000;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    t_regs();
    t_run();
    t_sync(16'h800A, s);
    t_sync(16'h800E, t);
    chk(16'(t - s), 16'h0014);
    t_slave();
    t_cable();
    summarize();
  end
endmodule
